/* File: hw/psmf_top.sv */
// parameter store, activation paths, factory restore and the two smoothing paths
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`default_nettype none
`timescale 1ns/1ps
module psmf_top #(
	parameter int unsigned HOLD_CYC = psmf_pkg::HOLD_CYC_DEF,
	parameter int          AW       = 8
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [AW-1:0]      s_axi_awaddr,
	input  wire logic [2:0]         s_axi_awprot,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [AW-1:0]      s_axi_araddr,
	input  wire logic [2:0]         s_axi_arprot,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	output logic [3:0]              nv_rd_addr,
	input  wire logic [31:0]        nv_rd_data,
	output logic                    cfg_ready,
	input  wire logic               ctl_wr_valid,
	input  wire logic [3:0]         ctl_wr_idx,
	input  wire logic [31:0]        ctl_wr_data,
	input  wire logic               ctl_online,
	input  wire logic               ctl_ladder,
	input  wire logic               asm_active,
	input  wire logic [3:0]         ctl_rd_idx,
	output logic [31:0]             ctl_rd_data,
	input  wire logic [9:0]         addr_sw,
	input  wire logic               preset_btn,
	input  wire logic               vel_raw_valid,
	input  wire logic signed [31:0] vel_raw,
	input  wire logic               acc_raw_valid,
	input  wire logic signed [31:0] acc_raw,
	input  wire logic signed [15:0] temp_c,
	input  wire logic signed [31:0] phys_pos,
	input  wire logic signed [31:0] range_off,
	output logic signed [31:0]      vel_out,
	output logic signed [31:0]      acc_out,
	output logic                    vel_over,
	output logic                    acc_over,
	output logic                    temp_over,
	output logic signed [31:0]      preset_off
);
	import psmf_pkg::*;
	psmf_state_type       st_r, st_nxt;
	logic [3:0]           ld_r, ld_nxt;
	logic [31:0]          work_r [NUM_PARAM];
	logic [31:0]          work_nxt [NUM_PARAM];
	logic [31:0]          pend_r [NUM_PARAM];
	logic [31:0]          pend_nxt [NUM_PARAM];
	logic [NUM_PARAM-1:0] pmask_r, pmask_nxt;
	logic                 online_q_r, fact_req_r, fact_req_nxt;
	logic                 have_aw_r, have_aw_nxt, have_w_r, have_w_nxt;
	logic [AW-1:0]        aw_addr_r, aw_addr_nxt;
	logic [31:0]          w_data_r, w_data_nxt;
	logic [3:0]           w_strb_r, w_strb_nxt;
	logic                 awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic [1:0]           bresp_nxt, rresp_nxt;
	logic [31:0]          rdata_nxt;
	logic                 wr_go, web_wr, web_lock, svc_fire, wr_err;
	logic [3:0]           widx, ridx;
	logic [31:0]          merged;
	logic [31:0]          hold_r, hold_nxt;
	logic                 btn_fire_r, btn_fire_nxt;
	logic                 vel_fv, acc_fv;
	logic signed [31:0]   vel_f, acc_f;
	logic signed [63:0]   vel_wide, acc_wide, vel_half;
	logic signed [31:0]   temp_conv;

	// speed and acceleration each get their own averaging and low-pass pair
	psmf_filter #(.DW(32), .MAXW(129)) u_vel_filt (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.in_valid (vel_raw_valid),
		.in_data  (vel_raw),
		.avg_set  ((work_r[IDX_VEL_AVG][7:0] > AVG_MAX) ? AVG_MAX : work_r[IDX_VEL_AVG][7:0]),
		.bw       ((work_r[IDX_VEL_BW][9:0] > BW_MAX) ? BW_MAX : work_r[IDX_VEL_BW][9:0]),
		.out_valid(vel_fv),
		.out_data (vel_f)
	);
	psmf_filter #(.DW(32), .MAXW(129)) u_acc_filt (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.in_valid (acc_raw_valid),
		.in_data  (acc_raw),
		.avg_set  ((work_r[IDX_ACC_AVG][7:0] > AVG_MAX) ? AVG_MAX : work_r[IDX_ACC_AVG][7:0]),
		.bw       ((work_r[IDX_ACC_BW][9:0] > BW_MAX) ? BW_MAX : work_r[IDX_ACC_BW][9:0]),
		.out_valid(acc_fv),
		.out_data (acc_f)
	);

	// write decode: held address and data meet, then one response
	always_comb begin
		wr_go = have_aw_r && have_w_r && !s_axi_bvalid && st_r == ST_RUN;
		widx = param_idx(aw_addr_r);
		web_lock = asm_active && widx <= IDX_ASM_LAST;
		web_wr = wr_go && param_hit(aw_addr_r) && !web_lock;
		svc_fire = wr_go && {aw_addr_r[7:2], 2'h0} == OFF_SVC &&
			w_strb_r[2:0] == 3'h7 && w_data_r[23:0] == SVC_FACTORY;
		wr_err = !(web_wr || svc_fire);
		merged = work_r[widx];
		for (int b = 0; b < 4; b++)
			if (w_strb_r[b])
				merged[8*b +: 8] = w_data_r[8*b +: 8];
	end

	// store: power-up load, factory restore, then live writes from both sides
	always_comb begin
		st_nxt = st_r;
		ld_nxt = ld_r;
		work_nxt = work_r;
		pend_nxt = pend_r;
		pmask_nxt = pmask_r;
		fact_req_nxt = fact_req_r | btn_fire_r | svc_fire;
		case (st_r)
			ST_LOAD: begin
				// memory answers one cycle after the address
				if (ld_r != 4'h0)
					work_nxt[4'(ld_r - 4'h1)] = nv_rd_data;
				if (ld_r == 4'(NUM_PARAM))
					st_nxt = ST_RUN;
				else
					ld_nxt = ld_r + 4'h1;
			end
			ST_FACT: begin
				for (int i = 0; i < NUM_PARAM; i++)
					if (4'(i) != IDX_TMP_LIM)
						work_nxt[i] = FACT_VAL[i];
				fact_req_nxt = btn_fire_r | svc_fire;
				st_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (web_wr)
					work_nxt[widx] = merged;
				// staged controller values go live on the rise to online
				if (ctl_online && !online_q_r) begin
					for (int i = 0; i < NUM_PARAM; i++)
						if (pmask_r[i])
							work_nxt[i] = pend_r[i];
					pmask_nxt = '0;
				end
				// controller ladder write wins over a web write in the same cycle
				if (ctl_wr_valid && ctl_wr_idx < 4'(NUM_PARAM)) begin
					if (ctl_ladder)
						work_nxt[ctl_wr_idx] = ctl_wr_data;
					else begin
						pend_nxt[ctl_wr_idx] = ctl_wr_data;
						pmask_nxt[ctl_wr_idx] = 1'b1;
					end
				end
				if (fact_req_r)
					st_nxt = ST_FACT;
			end
			default: st_nxt = ST_LOAD;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= ST_LOAD;
			ld_r <= 4'h0;
			pmask_r <= '0;
			online_q_r <= 1'b0;
			fact_req_r <= 1'b0;
			for (int i = 0; i < NUM_PARAM; i++) begin
				work_r[i] <= FACT_VAL[i];
				pend_r[i] <= 32'h0000_0000;
			end
		end else begin
			st_r <= st_nxt;
			ld_r <= ld_nxt;
			work_r <= work_nxt;
			pend_r <= pend_nxt;
			pmask_r <= pmask_nxt;
			online_q_r <= ctl_online;
			fact_req_r <= fact_req_nxt;
		end
	end

	// button hold: fires once per press, re-arms on release
	always_comb begin
		hold_nxt = hold_r;
		btn_fire_nxt = 1'b0;
		if (!preset_btn || addr_sw != SW_FACTORY)
			hold_nxt = 32'h0000_0000;
		else if (hold_r <= HOLD_CYC) begin
			hold_nxt = hold_r + 32'h0000_0001;
			btn_fire_nxt = (hold_r == HOLD_CYC);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_r <= 32'h0000_0000;
			btn_fire_r <= 1'b0;
		end else begin
			hold_r <= hold_nxt;
			btn_fire_r <= btn_fire_nxt;
		end
	end

	// bus channels; ready drops while an item is held or a response waits
	always_comb begin
		have_aw_nxt = have_aw_r;
		have_w_nxt = have_w_r;
		aw_addr_nxt = aw_addr_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = s_axi_bvalid;
		bresp_nxt = s_axi_bresp;
		rvalid_nxt = s_axi_rvalid;
		rresp_nxt = s_axi_rresp;
		rdata_nxt = s_axi_rdata;
		ridx = param_idx(s_axi_araddr);
		if (s_axi_awvalid && s_axi_awready) begin
			have_aw_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			have_w_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb_nxt = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			bvalid_nxt = 1'b0;
		if (wr_go) begin
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_err ? RESP_SLVERR : RESP_OKAY;
			have_aw_nxt = 1'b0;
			have_w_nxt = 1'b0;
		end
		if (s_axi_rvalid && s_axi_rready)
			rvalid_nxt = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'h0})
				OFF_STATUS: rdata_nxt = {27'h000_0000, |pmask_r, asm_active,
					ctl_online, st_r};
				OFF_SVC:    rdata_nxt = 32'h0000_0000;
				OFF_VEL:    rdata_nxt = vel_out;
				OFF_ACC:    rdata_nxt = acc_out;
				OFF_PRESET: rdata_nxt = preset_off;
				default: begin
					rdata_nxt = param_hit(s_axi_araddr) ? work_r[ridx] : 32'h0000_0000;
					rresp_nxt = param_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				end
			endcase
		end
		awready_nxt = !have_aw_nxt && !bvalid_nxt;
		wready_nxt = !have_w_nxt && !bvalid_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			have_aw_r <= 1'b0;
			have_w_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			have_aw_r <= have_aw_nxt;
			have_w_r <= have_w_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_wready <= wready_nxt;
			s_axi_bvalid <= bvalid_nxt;
			s_axi_bresp <= bresp_nxt;
			s_axi_arready <= arready_nxt;
			s_axi_rvalid <= rvalid_nxt;
			s_axi_rresp <= rresp_nxt;
			s_axi_rdata <= rdata_nxt;
		end
	end

	// unit conversion; large counts/s2 values wrap, 32 bits is the reporting limit
	always_comb begin
		vel_wide = 64'(vel_f) * 64'(VEL_DIV60_MUL);
		acc_wide = 64'(acc_f) * 64'(ACC_MS2_TO_S2);
		// the multiplier sits just under 1/60, so add half a step before the shift
		vel_half = 64'sh0000_0000_0000_0001 <<< (VEL_DIV60_SHIFT - 1);
		temp_conv = (work_r[IDX_TMP_FMT][0] == FMT_ALT) ?
			32'((32'(temp_c) * 32'sd9) / 32'sd5 + 32'sd32) : 32'(temp_c);
	end

	// outputs, all registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vel_out <= 32'h0000_0000;
			acc_out <= 32'h0000_0000;
			vel_over <= 1'b0;
			acc_over <= 1'b0;
			temp_over <= 1'b0;
			preset_off <= 32'h0000_0000;
			nv_rd_addr <= 4'h0;
			cfg_ready <= 1'b0;
			ctl_rd_data <= 32'h0000_0000;
		end else begin
			if (vel_fv)
				vel_out <= (work_r[IDX_VEL_FMT][0] == FMT_ALT) ?
					32'((vel_wide + vel_half) >>> VEL_DIV60_SHIFT) : vel_f;
			if (acc_fv)
				acc_out <= (work_r[IDX_ACC_FMT][0] == FMT_ALT) ? 32'(acc_wide) : acc_f;
			// limits are compared as stored, in whatever unit is selected now
			vel_over <= vel_out > $signed(work_r[IDX_VEL_LIM]);
			acc_over <= acc_out > $signed(work_r[IDX_ACC_LIM]);
			temp_over <= temp_conv > $signed(work_r[IDX_TMP_LIM]);
			preset_off <= work_r[IDX_ROUND][0] ? phys_pos + range_off : phys_pos;
			nv_rd_addr <= ld_nxt;
			cfg_ready <= (st_nxt == ST_RUN);
			ctl_rd_data <= (ctl_rd_idx < 4'(NUM_PARAM)) ? work_r[ctl_rd_idx] : 32'h0000_0000;
		end
	end
endmodule // psmf_top
`default_nettype wire

/* File: hw/psmf_pkg.sv */
// constants, types and helpers shared by the parameter store and its motion filters
`default_nettype none
package psmf_pkg;
	// parameter slots of the working store
	localparam int NUM_PARAM = 11;
	localparam logic [3:0] IDX_VEL_FMT = 4'h0;
	localparam logic [3:0] IDX_ACC_FMT = 4'h1;
	localparam logic [3:0] IDX_TMP_FMT = 4'h2;
	localparam logic [3:0] IDX_ROUND   = 4'h3;
	localparam logic [3:0] IDX_VEL_AVG = 4'h4;
	localparam logic [3:0] IDX_VEL_BW  = 4'h5;
	localparam logic [3:0] IDX_ACC_AVG = 4'h6;
	localparam logic [3:0] IDX_ACC_BW  = 4'h7;
	localparam logic [3:0] IDX_VEL_LIM = 4'h8;
	localparam logic [3:0] IDX_ACC_LIM = 4'h9;
	localparam logic [3:0] IDX_TMP_LIM = 4'hA;
	localparam logic [3:0] IDX_ASM_LAST = 4'h7; // slots carried by the configuration assembly
	// factory contents; the temperature limit is never restored
	localparam logic [31:0] FACT_VAL [NUM_PARAM] = '{
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0001, 32'h0000_0064, 32'h0000_0001, 32'h0000_0064,
		32'h0000_2EE0, 32'h3FFF_FFFF, 32'h0000_0055};
	localparam logic [7:0] AVG_MAX = 8'h80;
	localparam logic [9:0] BW_MAX  = 10'h3E8;
	// unit codes
	localparam logic FMT_BASE = 1'b0; // turns/min, counts/ms2, degC
	localparam logic FMT_ALT  = 1'b1; // turns/s, counts/s2, degF
	localparam logic signed [31:0] VEL_DIV60_MUL = 32'sh0011_1111;
	localparam int VEL_DIV60_SHIFT = 26;
	localparam logic signed [31:0] ACC_MS2_TO_S2 = 32'sh000F_4240;
	// register byte addresses
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_SVC    = 8'h04;
	localparam logic [7:0] OFF_VEL    = 8'h08;
	localparam logic [7:0] OFF_ACC    = 8'h0C;
	localparam logic [7:0] OFF_PRESET = 8'h10;
	localparam logic [7:0] OFF_PARAM0 = 8'h40;
	// service word: class [23:16], service code [15:8], data [7:0]
	localparam logic [23:0] SVC_FACTORY = 24'h23_0501;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// switch code and hold time for the button path
	localparam logic [9:0] SW_FACTORY = 10'h378; // decimal 888
	localparam longint HOLD_MS = 5000;
	localparam longint CLK_HZ  = 250000000;
	localparam int unsigned HOLD_CYC_DEF = 32'(HOLD_MS * CLK_HZ / 1000);
	// raw sample rate and low-pass coefficient scale (Q16)
	localparam longint SAMPLE_HZ = 1000;
	localparam longint ALPHA_PER_HZ = 2 * 314159 * 65536 / (100000 * SAMPLE_HZ);
	typedef enum logic [1:0] {
		ST_LOAD = 2'h0,
		ST_RUN  = 2'h1,
		ST_FACT = 2'h3
	} psmf_state_type;
	// coefficient of the recursive stage from the cutoff in Hz
	function automatic logic [16:0] alpha_of(input logic [9:0] bw);
		logic [31:0] a;
		a = 32'(bw) * 32'(ALPHA_PER_HZ);
		return (a > 32'h0000_FFFF) ? 17'h0_FFFF : a[16:0];
	endfunction
	// parameter window decode, shared by read and write paths
	function automatic logic param_hit(input logic [7:0] a);
		return ({a[7:2], 2'h0} >= OFF_PARAM0) &&
			({a[7:2], 2'h0} < 8'(OFF_PARAM0 + 8'(NUM_PARAM * 4)));
	endfunction
	function automatic logic [3:0] param_idx(input logic [7:0] a);
		logic [7:0] d;
		d = {a[7:2], 2'h0} - OFF_PARAM0;
		return d[5:2];
	endfunction
endpackage
`default_nettype wire

/* File: hw/psmf_filter.sv */
// one smoothing path: moving average over a window, then a first-order low-pass
`default_nettype none
`timescale 1ns/1ps
module psmf_filter #(
	parameter int DW   = 32,
	parameter int MAXW = 129
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 in_valid,
	input  wire logic signed [DW-1:0] in_data,
	input  wire logic [7:0]           avg_set,
	input  wire logic [9:0]           bw,
	output logic                      out_valid,
	output logic signed [DW-1:0]      out_data
);
	import psmf_pkg::*;
	localparam int SW = DW + 8;
	localparam int YW = DW + 16;
	logic signed [DW-1:0] win_mem [MAXW];
	logic [7:0]           wp_r, wp_nxt, fill_r, fill_nxt, avg_q_r;
	logic signed [SW-1:0] sum_r, sum_nxt;
	logic                 busy_r, busy_nxt, neg_r, neg_nxt, ov_r, ov_nxt;
	logic [5:0]           cnt_r, cnt_nxt;
	logic [SW-1:0]        num_r, num_nxt, quo_r, quo_nxt, rem_r, rem_nxt;
	logic [8:0]           den_r, den_nxt;
	logic signed [YW-1:0] y_r, y_nxt;
	logic [8:0]           wlen;
	logic signed [SW-1:0] xs, mean;
	logic signed [YW:0]   diff;
	logic signed [YW+17:0] prod;
	logic [SW:0]          trial;

	// window, divider and recursive stage; a change of avg_set restarts the window
	always_comb begin
		wlen = 9'(avg_set) + 9'h001;
		xs = SW'(in_data);
		wp_nxt = wp_r;
		fill_nxt = fill_r;
		sum_nxt = sum_r;
		busy_nxt = busy_r;
		neg_nxt = neg_r;
		cnt_nxt = cnt_r;
		num_nxt = num_r;
		quo_nxt = quo_r;
		rem_nxt = rem_r;
		den_nxt = den_r;
		y_nxt = y_r;
		ov_nxt = 1'b0;
		mean = '0;
		diff = '0;
		prod = '0;
		trial = '0;
		if (avg_q_r != avg_set) begin
			wp_nxt = 8'h00;
			fill_nxt = 8'h00;
			sum_nxt = '0;
		end else if (in_valid) begin
			if (9'(fill_r) == wlen)
				sum_nxt = sum_r + xs - SW'(win_mem[wp_r]);
			else begin
				sum_nxt = sum_r + xs;
				fill_nxt = fill_r + 8'h01;
			end
			wp_nxt = (9'(wp_r) + 9'h001 == wlen) ? 8'h00 : wp_r + 8'h01;
			neg_nxt = sum_nxt[SW-1];
			num_nxt = sum_nxt[SW-1] ? SW'(-sum_nxt) : SW'(sum_nxt);
			den_nxt = 9'(fill_nxt);
			quo_nxt = '0;
			rem_nxt = '0;
			cnt_nxt = 6'(SW);
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			// restoring division, one quotient bit per cycle
			trial = {rem_r, num_r[SW-1]};
			num_nxt = {num_r[SW-2:0], 1'b0};
			if (trial >= (SW+1)'(den_r)) begin
				rem_nxt = SW'(trial - (SW+1)'(den_r));
				quo_nxt = {quo_r[SW-2:0], 1'b1};
			end else begin
				rem_nxt = trial[SW-1:0];
				quo_nxt = {quo_r[SW-2:0], 1'b0};
			end
			cnt_nxt = cnt_r - 6'h01;
			if (cnt_r == 6'h01) begin
				busy_nxt = 1'b0;
				mean = neg_r ? -$signed(quo_nxt) : $signed(quo_nxt);
				// cutoff zero switches the low-pass off
				if (bw == 10'h000)
					y_nxt = {mean[DW-1:0], 16'h0000};
				else begin
					diff = (YW+1)'($signed({mean[DW-1:0], 16'h0000})) - (YW+1)'(y_r);
					prod = (YW+18)'(diff) * (YW+18)'($signed({1'b0, alpha_of(bw)}));
					y_nxt = y_r + YW'(prod >>> 16);
				end
				ov_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp_r <= 8'h00;
			fill_r <= 8'h00;
			avg_q_r <= 8'h00;
			sum_r <= '0;
			busy_r <= 1'b0;
			neg_r <= 1'b0;
			cnt_r <= 6'h00;
			num_r <= '0;
			quo_r <= '0;
			rem_r <= '0;
			den_r <= 9'h001;
			y_r <= '0;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			wp_r <= wp_nxt;
			fill_r <= fill_nxt;
			avg_q_r <= avg_set;
			sum_r <= sum_nxt;
			busy_r <= busy_nxt;
			neg_r <= neg_nxt;
			cnt_r <= cnt_nxt;
			num_r <= num_nxt;
			quo_r <= quo_nxt;
			rem_r <= rem_nxt;
			den_r <= den_nxt;
			y_r <= y_nxt;
			out_valid <= ov_nxt;
			out_data <= ov_nxt ? DW'(y_nxt >>> 16) : out_data;
		end
	end

	// sample memory holds no control state, so it needs no reset
	always_ff @(posedge aclk) begin
		if (in_valid && avg_q_r == avg_set)
			win_mem[wp_r] <= in_data;
	end
endmodule // psmf_filter
`default_nettype wire

/* File: verification/psmf_nvmem.sv */
// model of the non-volatile parameter memory that feeds the power-up load
`timescale 1ns/1ps
`default_nettype none
module psmf_nvmem (
	input  wire logic  aclk,
	input  wire logic [3:0] nv_rd_addr,
	output logic [31:0] nv_rd_data
);
	// stored image: round axis on, averages 3 and 1, low-pass off
	function automatic logic [31:0] img(input logic [3:0] i);
		case (i)
			4'h3, 4'h6: return 32'h0000_0001;
			4'h4: return 32'h0000_0003;
			4'h8, 4'h9: return 32'h7FFF_FFFF;
			4'hA: return 32'h0000_0064;
			default: return 32'h0000_0000;
		endcase
	endfunction
	// synchronous read: data belongs to the previous edge's address
	always_ff @(posedge aclk) nv_rd_data <= img(nv_rd_addr);
endmodule // psmf_nvmem
`default_nettype wire

/* File: verification/psmf_top_properties.sv */
// timing checks on the ports of the parameter store
`timescale 1ns/1ps
`default_nettype none
module psmf_top_properties (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        cfg_ready,
	input wire logic        ctl_wr_valid,
	input wire logic [3:0]  ctl_wr_idx,
	input wire logic [31:0] ctl_wr_data,
	input wire logic        ctl_ladder,
	input wire logic [3:0]  ctl_rd_idx,
	input wire logic [31:0] ctl_rd_data,
	input wire logic signed [31:0] phys_pos,
	input wire logic signed [31:0] range_off,
	input wire logic signed [31:0] preset_off
);
	import psmf_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ladder write whose slot is watched on the controller read port
	sequence ladder_wr;
		cfg_ready && ctl_wr_valid && ctl_ladder && ctl_wr_idx == ctl_rd_idx && ctl_wr_idx < 4'hB
		##1 ctl_rd_idx == $past(ctl_rd_idx) && !ctl_wr_valid;
	endsequence
	a_load_first: assert property ($rose(aresetn) |-> !cfg_ready [*8])
		else $error("store ready before load finished");
	a_restore_brief: assert property ($fell(cfg_ready) |=> cfg_ready)
		else $error("restore longer than one cycle");
	a_write_after_load: assert property ($rose(s_axi_bvalid) |-> cfg_ready)
		else $error("write answered outside run");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_preset_sum: assert property (cfg_ready && $stable(phys_pos) && $stable(range_off) |=>
		preset_off == $past(phys_pos) || preset_off == $past(phys_pos) + $past(range_off))
		else $error("preset offset wrong");
	a_ladder_apply: assert property (ladder_wr |=> ctl_rd_data == $past(ctl_wr_data, 2))
		else $error("ladder write not applied");
	cover property (ladder_wr);
	cover property ($fell(cfg_ready));
	cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule // psmf_top_properties
bind psmf_top psmf_top_properties chk (.*);
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench of the parameter store and smoothing paths
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import psmf_pkg::*;
	localparam int unsigned HOLD = 20;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, nv_rd_data, ctl_wr_data = '0, ctl_rd_data;
	logic [3:0] s_axi_wstrb = 4'hF, nv_rd_addr, ctl_wr_idx = '0, ctl_rd_idx = 4'h8;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cfg_ready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic ctl_wr_valid = 0, ctl_online = 0, ctl_ladder = 0, asm_active = 0, preset_btn = 0;
	logic vel_raw_valid = 0, acc_raw_valid = 0, vel_over, acc_over, temp_over;
	logic [9:0] addr_sw = '0;
	logic signed [31:0] vel_raw = '0, acc_raw = '0, phys_pos = '0, range_off = '0;
	logic signed [31:0] vel_out, acc_out, preset_off;
	logic signed [15:0] temp_c = 16'sh0028;
	int n_mismatch = 0, n_compared = 0, cyc = 0;
	psmf_top #(.HOLD_CYC(HOLD)) dut (.*);
	psmf_nvmem nv (.aclk(aclk), .nv_rd_addr(nv_rd_addr), .nv_rd_data(nv_rd_data));
	always #2 aclk = ~aclk;
	// hang guard
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic [7:0] sa(input int i);
		return 8'(OFF_PARAM0 + 4 * i);
	endfunction
	// both channels offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk("bresp", 32'(r), 32'(e));
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk("rdata", d, e);
	endtask
	// one raw sample on both paths, then time for the mean to settle
	task automatic samp(input logic signed [31:0] v, input logic signed [31:0] a);
		@(posedge aclk);
		vel_raw <= v;
		acc_raw <= a;
		vel_raw_valid <= 1'b1;
		acc_raw_valid <= 1'b1;
		@(posedge aclk);
		vel_raw_valid <= 1'b0;
		acc_raw_valid <= 1'b0;
		repeat (60) @(posedge aclk);
	endtask
	task automatic ctl_wr(input logic [3:0] i, input logic [31:0] d);
		@(posedge aclk);
		ctl_wr_valid <= 1'b1;
		ctl_wr_idx <= i;
		ctl_wr_data <= d;
		@(posedge aclk);
		ctl_wr_valid <= 1'b0;
	endtask
	task automatic t_load();
		for (int i = 0; i < NUM_PARAM; i++) rd_chk(sa(i), nv.img(4'(i)));
	endtask
	task automatic t_filter();
		for (int k = 0; k < 5; k++) samp((k == 4) ? 32'sh0000_0190 : 32'sh0000_0000,
			(k == 4) ? 32'sh0000_00C8 : 32'sh0000_0000);
		chk("vel_out", vel_out, 32'h0000_0064);
		chk("acc_out", acc_out, 32'h0000_0064);
		samp(32'sh0000_0190, 32'sh0000_00C8);
		chk("vel_out", vel_out, 32'h0000_00C8);
		chk("acc_out", acc_out, 32'h0000_00C8);
	endtask
	task automatic t_unit();
		wr_chk(sa(1), 32'h0000_0001, RESP_OKAY);
		wr_chk(sa(9), 32'h08F0_D180, RESP_OKAY);
		samp(32'sh0000_0190, 32'sh0000_00C8);
		chk("acc_out", acc_out, 32'h0BEB_C200);
		chk("acc_over", 32'(acc_over), 32'h0000_0001);
		rd_chk(OFF_ACC, 32'h0BEB_C200);
		chk("temp_over", 32'(temp_over), 32'h0000_0000);
		wr_chk(sa(2), 32'h0000_0001, RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk("temp_over", 32'(temp_over), 32'h0000_0001);
		// window becomes 400,400,400,240: mean 360 turns/min is 6 turns/s
		wr_chk(sa(0), 32'h0000_0001, RESP_OKAY);
		samp(32'sh0000_00F0, 32'sh0000_00C8);
		chk("vel_out", vel_out, 32'h0000_0006);
	endtask
	task automatic t_preset();
		phys_pos <= 32'sh0000_03E8;
		range_off <= 32'sh0000_0010;
		repeat (3) @(posedge aclk);
		chk("preset_off", preset_off, 32'h0000_03F8);
		wr_chk(sa(3), 32'h0000_0000, RESP_OKAY);
		repeat (3) @(posedge aclk);
		rd_chk(OFF_PRESET, 32'h0000_03E8);
	endtask
	task automatic t_asm();
		logic [31:0] d;
		logic [1:0] r;
		asm_active <= 1'b1;
		wr_chk(sa(4), 32'h0000_0005, RESP_SLVERR);
		wr_chk(sa(8), 32'h0000_1234, RESP_OKAY);
		asm_active <= 1'b0;
		wr_chk(sa(4), 32'h0000_0005, RESP_OKAY);
		rd_chk(sa(4), 32'h0000_0005);
		axi_rd(8'hFC, d, r);
		chk("rresp", 32'(r), 32'(RESP_SLVERR));
	endtask
	task automatic t_ctl();
		ctl_wr(4'h8, 32'h0000_AAAA);
		rd_chk(sa(8), 32'h0000_1234);
		ctl_online <= 1'b1;
		repeat (2) @(posedge aclk);
		rd_chk(sa(8), 32'h0000_AAAA);
		ctl_ladder <= 1'b1;
		ctl_wr(4'h8, 32'h0000_5555);
		repeat (2) @(posedge aclk);
		chk("ctl_rd_data", ctl_rd_data, 32'h0000_5555);
		rd_chk(sa(8), 32'h0000_5555);
		// limit 5 now reads as turns/s, below the reported 6
		ctl_wr(4'h8, 32'h0000_0005);
		repeat (2) @(posedge aclk);
		chk("vel_over", 32'(vel_over), 32'h0000_0001);
	endtask
	task automatic t_fact();
		wr_chk(OFF_SVC, 32'h0023_0502, RESP_SLVERR);
		wr_chk(OFF_SVC, 32'h0023_0501, RESP_OKAY);
		rd_chk(sa(8), FACT_VAL[8]);
		rd_chk(sa(10), 32'h0000_0064);
		rd_chk(sa(5), 32'h0000_0064);
		wr_chk(sa(4), 32'h0000_0005, RESP_OKAY);
		addr_sw <= SW_FACTORY;
		preset_btn <= 1'b1;
		repeat (HOLD - 5) @(posedge aclk);
		preset_btn <= 1'b0;
		rd_chk(sa(4), 32'h0000_0005);
		preset_btn <= 1'b1;
		repeat (HOLD + 5) @(posedge aclk);
		preset_btn <= 1'b0;
		rd_chk(sa(4), FACT_VAL[4]);
		// 100 Hz low-pass moves 360 toward 0 by 41100/65536 of the gap: 134
		samp(32'sh0000_0000, 32'sh0000_0000);
		chk("vel_out", vel_out, 32'h0000_0086);
	endtask
	// reset, wait for the load, then the scenarios
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 100 && cfg_ready !== 1'b1; i++) @(posedge aclk);
		t_load();
		t_filter();
		t_unit();
		t_preset();
		t_asm();
		t_ctl();
		t_fact();
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
